// file: drh_alarm_handler.sv
`timescale 1ns/1ps
// Function
// - alarm drops flag, stops motor, starts led
// - led blinks code-specific count, overtravel seven
// - clear input falling edge clears alarm
// - serial reset command clears alarm likewise
// - abs error cleared only by own path
// - keep ten newest alarms, drop oldest
// - history readable, erased by maintenance command
// - warning raised before alarm threshold
// - deviation over threshold with current on
// - current-on during off-deviation warning alarms
module drh_alarm_handler #(
  parameter int unsigned BLINK_HALF = drh_pkg::BLINK_HALF_CYC,
  parameter int unsigned BLINK_GAP = drh_pkg::BLINK_GAP_CYC,
  parameter logic [7:0] CODE_OVT = 8'h66,
  parameter logic [7:0] CODE_ABS = 8'h65,
  parameter logic [3:0] BLINK_DEV_OFF = 4'h4,
  parameter logic [3:0] BLINK_ABS = 4'h7
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [drh_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_clear_input,
  input wire logic abs_position_clear_input,
  input wire logic current_on,
  input wire logic overtravel_input,
  input wire logic abs_error_input,
  input wire logic [drh_pkg::DEV_W-1:0] position_deviation,
  output logic fault_flag_output,
  output logic motor_stop,
  output logic warning_output,
  output logic alarm_led
);
  import drh_pkg::*;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  function automatic logic [3:0] code_blinks(input logic [7:0] code);
    if (code == CODE_DEV) code_blinks = BLINK_DEV;
    else if (code == CODE_DEV_OFF) code_blinks = BLINK_DEV_OFF;
    else if (code == CODE_OVT) code_blinks = BLINK_OVT;
    else code_blinks = BLINK_ABS;
  endfunction : code_blinks

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  wire [SYNC_W-1:0] pins = {abs_error_input, overtravel_input, current_on,
                            abs_position_clear_input, fault_clear_input};

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (ce) begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire clr_fall = fell(sync3[0], sync2[0]);
  wire pclr_fall = fell(sync3[1], sync2[1]);
  wire cur_on = sync2[2];
  wire cur_on_rise = sync2[2] & ~sync3[2];
  wire ovt_fault = sync2[3];
  wire abs_fault = sync2[4];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [15:0] dev_alarm;
  logic [15:0] dev_warn_thr;
  logic [3:0] hist_sel;
  logic [3:0] hist_count;
  logic [7:0] hist [0:HIST_DEPTH-1];
  logic gen_active;
  logic abs_active;
  logic [7:0] gen_code;

  wire access = psel & penable & ~pready;
  wire wr_fire = psel & penable & pready & pwrite;
  wire a_ctrl = (paddr == ADDR_CTRL);
  wire a_dev_alarm = (paddr == ADDR_DEV_ALARM);
  wire a_dev_warn = (paddr == ADDR_DEV_WARN);
  wire a_hist_sel = (paddr == ADDR_HIST_SEL);
  wire mapped = a_ctrl | a_dev_alarm | a_dev_warn | a_hist_sel | (paddr == ADDR_STATUS)
                | (paddr == ADDR_HIST_DATA) | (paddr == ADDR_HIST_COUNT);
  wire cmd_reset = wr_fire & a_ctrl & pwdata[CTRL_RESET_BIT];
  wire cmd_abs_clear = wr_fire & a_ctrl & pwdata[CTRL_ABS_CLEAR_BIT];
  wire hist_clr = wr_fire & a_ctrl & pwdata[CTRL_HIST_CLEAR_BIT];
  wire [7:0] cur_code = abs_active ? CODE_ABS : gen_code;
  wire [7:0] hist_word = (hist_sel < hist_count) ? hist[hist_sel] : 8'h00;
  wire [31:0] status_word = (32'(cur_code) << ST_CODE_LSB) | (32'(gen_active) << ST_GEN_BIT)
                            | (32'(abs_active) << ST_ABS_BIT) | (32'(warning_output) << ST_WARN_BIT)
                            | (32'(hist_count) << ST_CNT_LSB);
  wire [31:0] next_prdata = (paddr == ADDR_STATUS) ? status_word :
                            a_dev_alarm ? 32'(dev_alarm) :
                            a_dev_warn ? 32'(dev_warn_thr) :
                            a_hist_sel ? 32'(hist_sel) :
                            (paddr == ADDR_HIST_DATA) ? 32'(hist_word) :
                            (paddr == ADDR_HIST_COUNT) ? 32'(hist_count) : 32'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      dev_alarm <= DEV_ALARM_RST;
      dev_warn_thr <= DEV_WARN_RST;
      hist_sel <= 4'h0;
    end else if (ce) begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite) prdata <= next_prdata;
      if (wr_fire && a_dev_alarm) dev_alarm <= pwdata[15:0];
      if (wr_fire && a_dev_warn) dev_warn_thr <= pwdata[15:0];
      if (wr_fire && a_hist_sel) hist_sel <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // fault detection and latching
  // ----------------------------------------------------------------
  logic off_warn_q;
  wire dev_over = cur_on & (position_deviation > dev_alarm);
  wire dev_warn = position_deviation > dev_warn_thr;
  wire off_warn = ~cur_on & dev_warn;
  wire con_rise = cur_on_rise & off_warn_q;
  wire gen_fault = dev_over | con_rise | ovt_fault;
  wire [7:0] fault_code = dev_over ? CODE_DEV : con_rise ? CODE_DEV_OFF : CODE_OVT;
  // abs error is left out of the ordinary clear on purpose
  wire gen_clear = clr_fall | cmd_reset;
  wire abs_clear = pclr_fall | cmd_abs_clear;
  // a fault seen in the clear cycle wins, so no event is dropped
  wire next_gen = gen_fault | (gen_active & ~gen_clear);
  wire next_abs = abs_fault | (abs_active & ~abs_clear);
  wire new_gen = gen_fault & ~gen_active;
  wire new_abs = abs_fault & ~abs_active;
  wire log_push = new_gen | new_abs;
  wire [7:0] log_code = new_abs ? CODE_ABS : fault_code;

  always_ff @(posedge clk) begin
    if (reset) begin
      off_warn_q <= 1'b0;
      gen_active <= 1'b0;
      abs_active <= 1'b0;
      gen_code <= 8'h00;
      fault_flag_output <= 1'b1;
      motor_stop <= 1'b0;
      warning_output <= 1'b0;
    end else if (ce) begin
      off_warn_q <= off_warn;
      gen_active <= next_gen;
      abs_active <= next_abs;
      if (new_gen) gen_code <= fault_code;
      fault_flag_output <= ~(next_gen | next_abs);
      motor_stop <= next_gen | next_abs;
      warning_output <= dev_warn | off_warn;
    end
  end

  // ----------------------------------------------------------------
  // alarm history, newest at index zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      hist_count <= 4'h0;
      for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= 8'h00;
    end else if (ce) begin
      if (log_push) begin
        hist[0] <= log_code;
        for (int i = 1; i < HIST_DEPTH; i++) hist[i] <= hist[i-1];
        if (hist_clr) hist_count <= 4'h1;
        else if (hist_count != 4'(HIST_DEPTH)) hist_count <= hist_count + 4'h1;
      end else if (hist_clr) begin
        hist_count <= 4'h0;
      end
    end
  end

  drh_blinker #(
    .HALF_CYC(BLINK_HALF),
    .GAP_CYC(BLINK_GAP)
  ) u_blinker (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .active(gen_active | abs_active),
    .count(code_blinks(cur_code)),
    .led(alarm_led)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fault_seen;
    ce && (gen_fault || abs_fault);
  endsequence
  sequence s_flag_off;
    !fault_flag_output && motor_stop;
  endsequence

  a_fault_stops: assert property (s_fault_seen |=> s_flag_off)
    else $error("fault did not drop flag and stop motor");
  a_pin_clear: assert property (ce && gen_active && clr_fall && !gen_fault && !abs_active && !abs_fault
    |=> fault_flag_output && !motor_stop)
    else $error("falling clear input did not clear alarm");
  a_cmd_clear: assert property (ce && cmd_reset && !gen_fault |=> !gen_active)
    else $error("reset command did not clear alarm");
  a_abs_kept: assert property (ce && abs_active && gen_clear && !abs_clear |=> abs_active && !fault_flag_output)
    else $error("ordinary reset cleared abs error");
  a_hist_push: assert property (ce && log_push |=> hist[0] == $past(log_code) && hist_count <= 4'(HIST_DEPTH))
    else $error("history entry not stored");
  a_hist_erase: assert property (ce && hist_clr && !log_push |=> hist_count == 4'h0)
    else $error("history not erased");
  a_warn_first: assert property (ce && dev_over && dev_warn_thr < dev_alarm |=> warning_output)
    else $error("alarm without preceding warning");
  a_dev_code: assert property (ce && dev_over && !gen_active |=> gen_active && gen_code == CODE_DEV)
    else $error("deviation alarm code wrong");
  a_off_code: assert property (ce && con_rise && !dev_over && !gen_active |=> gen_code == CODE_DEV_OFF)
    else $error("current-off deviation alarm code wrong");
  a_alarm_latched: assert property (ce && gen_active && !gen_clear ##1 !ce [*2] |-> !fault_flag_output)
    else $error("alarm released without reset");
endmodule : drh_alarm_handler

// file: drh_pkg.sv
package drh_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DEV_ALARM = 8'h08;
  localparam logic [7:0] ADDR_DEV_WARN = 8'h0c;
  localparam logic [7:0] ADDR_HIST_SEL = 8'h10;
  localparam logic [7:0] ADDR_HIST_DATA = 8'h14;
  localparam logic [7:0] ADDR_HIST_COUNT = 8'h18;
  // ctrl bits, write one to act, always read as zero
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_ABS_CLEAR_BIT = 1;
  localparam int CTRL_HIST_CLEAR_BIT = 2;
  // status fields
  localparam int ST_CODE_LSB = 0;
  localparam int ST_GEN_BIT = 8;
  localparam int ST_ABS_BIT = 9;
  localparam int ST_WARN_BIT = 10;
  localparam int ST_CNT_LSB = 12;
  // ----------------------------------------------------------------
  // alarm codes and blink counts
  // ----------------------------------------------------------------
  localparam int DEV_W = 16;
  localparam logic [15:0] DEV_ALARM_RST = 16'h0400;
  localparam logic [15:0] DEV_WARN_RST = 16'h0300;
  localparam logic [7:0] CODE_DEV = 8'h10;
  localparam logic [7:0] CODE_DEV_OFF = 8'h12;
  localparam logic [3:0] BLINK_DEV = 4'h4;
  localparam logic [3:0] BLINK_OVT = 4'h7;
  localparam int HIST_DEPTH = 10;
  localparam int SYNC_W = 5;
  // ----------------------------------------------------------------
  // led timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BLINK_HALF_NS = 200000000;
  localparam int BLINK_GAP_NS = 1000000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int BLINK_GAP_CYC = BLINK_GAP_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    BL_IDLE = 4'b0001,
    BL_ON = 4'b0010,
    BL_OFF = 4'b0100,
    BL_GAP = 4'b1000
  } drh_blink_state_t;
endpackage : drh_pkg

// file: drh_blinker.sv
`timescale 1ns/1ps
module drh_blinker #(
  parameter int unsigned HALF_CYC = drh_pkg::BLINK_HALF_CYC,
  parameter int unsigned GAP_CYC = drh_pkg::BLINK_GAP_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic active,
  input wire logic [3:0] count,
  output logic led
);
  import drh_pkg::*;

  drh_blink_state_t state;
  drh_blink_state_t next_state;
  logic [31:0] timer;
  logic [3:0] blinks;
  logic [3:0] count_q;
  wire half_done = (timer == 32'(HALF_CYC - 1));
  wire gap_done = (timer == 32'(GAP_CYC - 1));
  wire last_blink = (blinks == count_q);

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      BL_IDLE: if (active && count != 4'h0) next_state = BL_ON;
      BL_ON: if (half_done) next_state = BL_OFF;
      BL_OFF: if (half_done) next_state = last_blink ? BL_GAP : BL_ON;
      BL_GAP: if (gap_done) next_state = BL_IDLE;
      default: next_state = BL_IDLE;
    endcase
    // a cleared alarm stops the pattern at once
    if (!active) next_state = BL_IDLE;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= BL_IDLE;
      timer <= 32'h0;
      blinks <= 4'h0;
      count_q <= 4'h0;
      led <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      timer <= (next_state != state) ? 32'h0 : timer + 32'h1;
      // count is frozen per sequence so a code change never cuts a pattern short
      if (state == BL_IDLE) count_q <= count;
      // one count per finished lit phase, so the last off phase sees the full count
      if (state == BL_IDLE) blinks <= 4'h0;
      else if (state == BL_ON && next_state == BL_OFF) blinks <= blinks + 4'h1;
      led <= (next_state == BL_ON);
    end
  end

  a_blink_bound: assert property (@(posedge clk) disable iff (reset)
    (state == BL_ON) |-> (blinks < count_q))
    else $error("more blinks than the alarm code allows");
endmodule : drh_blinker

// file: drh_host_model.sv
`timescale 1ns/1ps
module drh_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [drh_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic fault_clear_input,
  output logic abs_position_clear_input,
  output logic current_on
);
  import drh_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_clear_input = 1'b0;
    abs_position_clear_input = 1'b0;
    current_on = 1'b0;
  end
  // ----------------------------------------------------------------
  // apb master: request held until pready is sampled high, or released after 20 cycles without it
  // ----------------------------------------------------------------
  // control and maintenance commands travel as ctrl writes
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output bit to);
    to = 1'b1;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 20 && to; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        to = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows an inverted pattern, not the last word
    pwdata <= ~wd;
  endtask : xfer
  // a clear is a full on-then-off pulse on the chosen pin
  task automatic pulse_clear(input bit abs_pin);
    @(posedge clk);
    if (abs_pin) abs_position_clear_input <= 1'b1;
    else fault_clear_input <= 1'b1;
    repeat (4) @(posedge clk);
    abs_position_clear_input <= 1'b0;
    fault_clear_input <= 1'b0;
  endtask : pulse_clear
  task automatic set_current(input logic on);
    @(posedge clk);
    current_on <= on;
  endtask : set_current
endmodule : drh_host_model

// file: drive_alarm_handler_test.sv
`timescale 1ns/1ps
module drive_alarm_handler_test;
  import drh_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} drh_row_t;
  localparam int HALF = 4;
  localparam int GAP = 10;
  localparam logic [7:0] OVT = 8'h66;
  logic clk, reset, ce, psel, penable, pwrite, pready, pslverr;
  logic fault_clear_input, abs_position_clear_input, current_on;
  logic overtravel_input, abs_error_input, fault_flag_output, motor_stop, warning_output, alarm_led;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DEV_W-1:0] position_deviation;
  logic er;
  int n_mismatch = 0;
  int checks_done = 0;
  drh_row_t rows [7] = '{'{ADDR_STATUS, 32'h0, 1'b0}, '{ADDR_DEV_ALARM, 32'h400, 1'b0},
    '{ADDR_DEV_WARN, 32'h300, 1'b0}, '{ADDR_HIST_COUNT, 32'h0, 1'b0}, '{ADDR_HIST_DATA, 32'h0, 1'b0},
    '{ADDR_CTRL, 32'h0, 1'b0}, '{8'h1c, 32'h0, 1'b1}};
  drh_alarm_handler #(.BLINK_HALF(HALF), .BLINK_GAP(GAP), .CODE_OVT(OVT)) drh_alarm_handler_i (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_clear_input(fault_clear_input), .abs_position_clear_input(abs_position_clear_input),
    .current_on(current_on), .overtravel_input(overtravel_input), .abs_error_input(abs_error_input),
    .position_deviation(position_deviation), .fault_flag_output(fault_flag_output),
    .motor_stop(motor_stop), .warning_output(warning_output), .alarm_led(alarm_led));
  drh_host_model drh_host_model_i (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_clear_input(fault_clear_input),
    .abs_position_clear_input(abs_position_clear_input), .current_on(current_on));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    bit to;
    drh_host_model_i.xfer(wr, a, wd, rd, er, to);
    if (to) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : bus
  task automatic cmd(input int b);
    bus(1'b1, ADDR_CTRL, 32'h1 << b);
    repeat (3) @(posedge clk);
  endtask : cmd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  // a dark spell longer than one half is the gap, so the window opens on a first blink
  // window of n blinks ends before the gap lets the next train start
  task automatic blinks(input logic [3:0] n);
    int k;
    int low;
    int rises;
    logic prev;
    k = 0;
    low = 0;
    rises = 1;
    prev = 1'b1;
    while (low <= HALF && k < 300) begin
      @(posedge clk);
      k++;
      low = (alarm_led === 1'b1) ? 0 : low + 1;
    end
    while (alarm_led !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (low <= HALF || alarm_led !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (int'(n) * 2 * HALF) begin
      @(posedge clk);
      if (alarm_led === 1'b1 && prev !== 1'b1) rises++;
      prev = alarm_led;
    end
    chk("led blinks", 32'(rises), 32'(n));
  endtask : blinks
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    overtravel_input = 1'b0;
    abs_error_input = 1'b0;
    position_deviation = 16'h0;
    wait_cyc(16);
    reset <= 1'b0;
    wait_cyc(1);
    chk("flag idle", fault_flag_output, 1'b1);
    chk("stop idle", motor_stop, 1'b0);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("reg read", rd, rows[i].d);
      chk("slverr", er, rows[i].e);
    end
    $display("test registers done");
    overtravel_input <= 1'b1;
    wait_cyc(5);
    chk("flag ovt", fault_flag_output, 1'b0);
    chk("stop ovt", motor_stop, 1'b1);
    blinks(BLINK_OVT);
    overtravel_input <= 1'b0;
    wait_cyc(10);
    chk("flag latched", fault_flag_output, 1'b0);
    drh_host_model_i.pulse_clear(1'b0);
    wait_cyc(6);
    chk("flag pin clear", fault_flag_output, 1'b1);
    chk("stop pin clear", motor_stop, 1'b0);
    $display("test overtravel done");
    position_deviation <= 16'h0350;
    wait_cyc(5);
    chk("warning", warning_output, 1'b1);
    chk("flag warn only", fault_flag_output, 1'b1);
    drh_host_model_i.set_current(1'b1);
    wait_cyc(6);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("code dev off", rd[7:0], CODE_DEV_OFF);
    chk("flag dev off", fault_flag_output, 1'b0);
    cmd(CTRL_RESET_BIT);
    chk("flag cmd clear", fault_flag_output, 1'b1);
    position_deviation <= 16'h0500;
    wait_cyc(5);
    chk("flag dev", fault_flag_output, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("code dev", rd[7:0], CODE_DEV);
    blinks(BLINK_DEV);
    position_deviation <= 16'h0;
    wait_cyc(2);
    cmd(CTRL_RESET_BIT);
    $display("test deviation done");
    abs_error_input <= 1'b1;
    wait_cyc(5);
    abs_error_input <= 1'b0;
    drh_host_model_i.pulse_clear(1'b0);
    cmd(CTRL_RESET_BIT);
    wait_cyc(3);
    chk("abs survives", fault_flag_output, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("abs active", rd[ST_ABS_BIT], 1'b1);
    drh_host_model_i.pulse_clear(1'b1);
    wait_cyc(6);
    chk("abs pin clear", fault_flag_output, 1'b1);
    abs_error_input <= 1'b1;
    wait_cyc(5);
    abs_error_input <= 1'b0;
    wait_cyc(4);
    cmd(CTRL_ABS_CLEAR_BIT);
    chk("abs cmd clear", fault_flag_output, 1'b1);
    $display("test abs done");
    // five logged so far; six more overflow the ten-entry log
    for (int i = 0; i < 6; i++) begin
      overtravel_input <= 1'b1;
      wait_cyc(5);
      overtravel_input <= 1'b0;
      wait_cyc(4);
      cmd(CTRL_RESET_BIT);
    end
    bus(1'b0, ADDR_HIST_COUNT, 32'h0);
    chk("hist full", rd, 32'd10);
    bus(1'b1, ADDR_HIST_SEL, 32'd9);
    bus(1'b0, ADDR_HIST_DATA, 32'h0);
    chk("hist oldest", rd[7:0], CODE_DEV_OFF);
    bus(1'b1, ADDR_HIST_SEL, 32'd0);
    bus(1'b0, ADDR_HIST_DATA, 32'h0);
    chk("hist newest", rd[7:0], OVT);
    cmd(CTRL_HIST_CLEAR_BIT);
    bus(1'b0, ADDR_HIST_COUNT, 32'h0);
    chk("hist erased", rd, 32'd0);
    $display("test history done");
    // clock enable low freezes the latch and hides a clear pulse from the pins
    overtravel_input <= 1'b1;
    wait_cyc(5);
    overtravel_input <= 1'b0;
    wait_cyc(4);
    ce <= 1'b0;
    drh_host_model_i.pulse_clear(1'b0);
    wait_cyc(6);
    ce <= 1'b1;
    wait_cyc(6);
    chk("flag frozen", fault_flag_output, 1'b0);
    chk("stop frozen", motor_stop, 1'b1);
    $display("test clock enable done");
    // reset in mid-run drops a latched alarm
    reset <= 1'b1;
    wait_cyc(2);
    reset <= 1'b0;
    wait_cyc(1);
    chk("flag reset", fault_flag_output, 1'b1);
    chk("stop reset", motor_stop, 1'b0);
    chk("led reset", alarm_led, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : drive_alarm_handler_test
